/* cmm_alu.sv */
/*
  package of the move and multiply slice, and its multiply and negate helper.
  assumes fetched operands; the caller samples outputs on the core clock.
*/
package cmm_pkg;
  // data path widths
  localparam int XLEN = 32;
  localparam int REG_COUNT = 16;
  // processor state word layout
  localparam int SW_SUPER_BIT = 13;
  localparam int SW_EXTEND_BIT = 4;
  localparam logic [15:0] SW_RESET = 16'h2000;
  localparam logic [15:0] FLAGS_MASK = 16'h00ff;
  // address space qualifiers for ordinary data accesses
  localparam logic [2:0] FC_USER_DATA = 3'h1;
  localparam logic [2:0] FC_SUPER_DATA = 3'h5;
  // control register select codes
  localparam logic [11:0] CTRL_SRC_SPACE = 12'h000;
  localparam logic [11:0] CTRL_DST_SPACE = 12'h001;
  localparam logic [11:0] CTRL_USER_STACK = 12'h800;
  localparam logic [11:0] CTRL_VECTOR_BASE = 12'h801;
  // byte-lane peripheral move geometry
  localparam logic [2:0] LANES_WORD = 3'h2;
  localparam logic [2:0] LANES_LONG = 3'h4;
  localparam logic [31:0] LANE_STEP = 32'h0000_0002;
  localparam logic [31:0] BYTE_MASK = 32'h0000_00ff;
  // register index bit that selects the address bank
  localparam logic [3:0] ADDR_BANK = 4'h8;
  // decimal radix for the negate
  localparam logic [4:0] BCD_RADIX = 5'h0a;

  typedef enum logic [3:0] {
    OP_USER_STACK_TRANSFER, OP_CONTROL_REGISTER_MOVE, OP_MULTI_REGISTER_TRANSFER,
    OP_BYTE_LANE_MOVE, OP_QUICK_IMMEDIATE_LOAD, OP_ALTERNATE_SPACE_MOVE,
    OP_MULTIPLY, OP_DECIMAL_NEGATE, OP_FLAGS_TO, OP_FLAGS_FROM,
    OP_STATE_TO, OP_STATE_FROM
  } cmm_op_e;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cmm_size_e;
  typedef enum logic [1:0] {MUL_W16, MUL_L32, MUL_L64} cmm_mul_e;
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_MEM} cmm_state_e;

  // one decoded instruction
  typedef struct packed {
    cmm_op_e op;
    cmm_size_e size;
    cmm_mul_e mul_mode;
    logic mul_signed;
    logic to_reg;
    logic [3:0] reg_a;
    logic [3:0] reg_b;
    logic [7:0] imm8;
    logic [15:0] disp16;
    logic [15:0] reg_list;
    logic [11:0] ctrl_code;
    logic [31:0] ea_addr;
    logic [31:0] src_data;
  } cmm_cmd_s;

  // one memory beat
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    cmm_size_e size;
    logic [2:0] fc;
  } cmm_mem_s;

  function automatic logic [31:0] sext8(input logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction

  function automatic logic [31:0] sext16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic logic [31:0] size_bytes(input cmm_size_e s);
    return (s == SZ_LONG) ? 32'h0000_0004 : 32'h0000_0002;
  endfunction

  // lowest numbered register still pending in a transfer list
  function automatic logic [3:0] lowest_set(input logic [15:0] list);
    logic [3:0] idx;
    idx = '0;
    for (int i = REG_COUNT - 1; i >= 0; i--) begin
      if (list[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // bit offset of a lane, lane 0 being the most significant byte
  function automatic logic [4:0] lane_shift(input logic [2:0] nl, input logic [2:0] lane);
    return {2'(nl - 3'h1 - lane), 3'h0};
  endfunction

  function automatic logic [3:0] addr_reg(input logic [3:0] sel);
    return sel | ADDR_BANK;
  endfunction

  function automatic logic [3:0] data_reg(input logic [3:0] sel);
    return sel & ~ADDR_BANK;
  endfunction
endpackage

`timescale 1ns/1ps
module cmm_alu (
  // multiplier operands
  input wire logic [31:0] mul_src,
  input wire logic [31:0] mul_dst,
  input wire logic mul_signed,
  input wire cmm_pkg::cmm_mul_e mul_mode,
  // decimal negate operand
  input wire logic [7:0] bcd_in,
  input wire logic extend_in,
  // results
  output logic [31:0] prod_lo,
  output logic [31:0] prod_hi,
  output logic [7:0] bcd_out
);
  // one wide multiply; the low 64 bits of an extended product are exact
  // for both signed and unsigned forms, so no separate signed array
  always_comb begin
    logic [63:0] a64;
    logic [63:0] b64;
    logic [63:0] p;
    a64 = '0;
    b64 = '0;
    // RULE7: sixteen or thirty-two bit operands
    if (mul_mode == cmm_pkg::MUL_W16) begin
      a64 = mul_signed ? {{48{mul_src[15]}}, mul_src[15:0]} : {48'h0, mul_src[15:0]};
      b64 = mul_signed ? {{48{mul_dst[15]}}, mul_dst[15:0]} : {48'h0, mul_dst[15:0]};
    end else begin
      a64 = mul_signed ? {{32{mul_src[31]}}, mul_src} : {32'h0, mul_src};
      b64 = mul_signed ? {{32{mul_dst[31]}}, mul_dst} : {32'h0, mul_dst};
    end
    p = a64 * b64;
    prod_lo = p[31:0];
    prod_hi = p[63:32];
  end

  // ten's complement of a packed byte, digit by digit with borrow
  always_comb begin
    logic [4:0] lo_in;
    logic [4:0] hi_in;
    logic [4:0] lo;
    logic [4:0] hi;
    logic borrow;
    // RULE8: zero minus operand minus extend
    lo_in = {1'b0, bcd_in[3:0]} + {4'h0, extend_in};
    borrow = (lo_in != 5'h00);
    lo = borrow ? 5'(cmm_pkg::BCD_RADIX - lo_in) : 5'h00;
    hi_in = {1'b0, bcd_in[7:4]} + {4'h0, borrow};
    hi = (hi_in != 5'h00) ? 5'(cmm_pkg::BCD_RADIX - hi_in) : 5'h00;
    bcd_out = {hi[3:0], lo[3:0]};
  end
endmodule

/* cmm_core.sv */
/*
  move and multiply execution slice: stack, control, list, lane, space,
  quick, multiply, negate and state word alternate_space_move.
  assumes fetched operands and addresses, and one ack per memory beat.
*/
// How it works
// RULE1: user stack pointer to or from address register
// RULE2: control register alternate_space_move either way, thirty-two bits except the three-bit space codes
// RULE3: register list stored or loaded, words extended
// RULE4: byte lanes high first, two byte address step
// RULE5: eight-bit immediate sign extended into data register
// RULE6: destination space writes, source space reads
// RULE7: multiply sixteen or thirty-two bit operands, thirty-two or sixty-four bit result
// RULE8: packed decimal byte negated with extend flag
// RULE9: privileged alternate_space_move fault outside supervisor state
// RULE10: flag writes touch only the low byte
`timescale 1ns/1ps
module cmm_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // decoded instruction stream
  input wire logic cmd_valid,
  input wire cmm_pkg::cmm_cmd_s cmd,
  output logic cmd_ready,
  output logic done,
  output logic priv_fault,
  // effective-address destination result
  output logic res_valid,
  output logic [31:0] res_data,
  // memory operand port
  output logic mem_req,
  output cmm_pkg::cmm_mem_s mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // register file load and inspection
  input wire logic rf_wr_en,
  input wire logic [3:0] rf_wr_sel,
  input wire logic [31:0] rf_wr_data,
  input wire logic [3:0] rf_rd_sel,
  output logic [31:0] rf_rd_data,
  // architectural state
  output logic [15:0] processor_state_word,
  output logic [31:0] user_stack_pointer
);
  // data registers 0..7 then address registers 8..15
  logic [31:0] rf_r [cmm_pkg::REG_COUNT];
  logic [15:0] sw_r; // processor state word, flags in the low byte
  logic [31:0] usp_r; // user stack pointer
  logic [31:0] vbr_r; // vector base, only reachable by control alternate_space_move
  logic [2:0] sfc_r; // source space code
  logic [2:0] dfc_r; // destination space code
  cmm_pkg::cmm_state_e state_r;
  cmm_pkg::cmm_cmd_s cmd_r; // instruction held during memory beats
  logic [15:0] list_r; // registers still to transfer
  logic [31:0] addr_r; // address of the next beat
  logic [2:0] lane_r; // beats issued so far for lane and space alternate_space_move
  logic [3:0] cur_r; // register or lane of the beat in flight
  cmm_pkg::cmm_mem_s mem_r;
  logic done_r;
  logic fault_r;
  logic res_valid_r;
  logic [31:0] res_r;
  // helper outputs
  logic [31:0] prod_lo;
  logic [31:0] prod_hi;
  logic [7:0] bcd_out;
  // accept and write port controls
  logic supervisor;
  logic is_priv;
  logic is_mem;
  logic take;
  logic fault_now;
  logic fire;
  logic mem_load;
  logic [2:0] nlanes;
  logic [3:0] dreg_a;
  logic [31:0] ctrl_rd;
  logic wa_en;
  logic [3:0] wa_sel;
  logic [31:0] wa_data;
  logic wb_en;
  logic [3:0] wb_sel;
  // next beat
  logic beat_left;
  logic [3:0] beat_cur;
  logic [31:0] beat_step;
  cmm_pkg::cmm_mem_s beat;

  assign supervisor = sw_r[cmm_pkg::SW_SUPER_BIT];
  assign cmd_ready = (state_r == cmm_pkg::ST_IDLE);
  assign take = cmd_valid && cmd_ready;
  assign dreg_a = cmm_pkg::data_reg(cmd.reg_a);
  assign nlanes = (cmd_r.size == cmm_pkg::SZ_LONG) ? cmm_pkg::LANES_LONG : cmm_pkg::LANES_WORD;
  assign mem_load = (state_r == cmm_pkg::ST_MEM) && mem_ack && !mem_r.we;
  assign rf_rd_data = rf_r[rf_rd_sel];
  assign processor_state_word = sw_r;
  assign user_stack_pointer = usp_r;
  assign mem_req = (state_r == cmm_pkg::ST_MEM);
  assign mem = mem_r;
  assign done = done_r;
  assign priv_fault = fault_r;
  assign res_valid = res_valid_r;
  assign res_data = res_r;

  // classify the incoming instruction
  always_comb begin
    is_priv = 1'b0;
    is_mem = 1'b0;
    case (cmd.op)
      cmm_pkg::OP_USER_STACK_TRANSFER, cmm_pkg::OP_CONTROL_REGISTER_MOVE,
      cmm_pkg::OP_STATE_TO, cmm_pkg::OP_STATE_FROM: is_priv = 1'b1;
      cmm_pkg::OP_ALTERNATE_SPACE_MOVE: begin
        is_priv = 1'b1;
        is_mem = 1'b1;
      end
      cmm_pkg::OP_MULTI_REGISTER_TRANSFER, cmm_pkg::OP_BYTE_LANE_MOVE: is_mem = 1'b1;
      default: ;
    endcase
  end

  // RULE9: privileged op without supervisor never executes
  assign fault_now = take && is_priv && !supervisor;
  assign fire = take && !fault_now;

  // control register read mux; unknown codes read as zero
  always_comb begin
    case (cmd.ctrl_code)
      cmm_pkg::CTRL_SRC_SPACE: ctrl_rd = {29'h0, sfc_r};
      cmm_pkg::CTRL_DST_SPACE: ctrl_rd = {29'h0, dfc_r};
      cmm_pkg::CTRL_USER_STACK: ctrl_rd = usp_r;
      cmm_pkg::CTRL_VECTOR_BASE: ctrl_rd = vbr_r;
      default: ctrl_rd = '0;
    endcase
  end

  cmm_alu u_alu (
    .mul_src(cmd.src_data),
    .mul_dst(rf_r[dreg_a]),
    .mul_signed(cmd.mul_signed),
    .mul_mode(cmd.mul_mode),
    .bcd_in(cmd.src_data[7:0]),
    .extend_in(sw_r[cmm_pkg::SW_EXTEND_BIT]),
    .prod_lo(prod_lo),
    .prod_hi(prod_hi),
    .bcd_out(bcd_out)
  );

  // register file write ports; instruction writes win over the load port
  always_comb begin
    logic [31:0] old;
    logic [4:0] sh;
    old = '0;
    sh = '0;
    wa_en = 1'b0;
    wa_sel = rf_wr_sel;
    wa_data = rf_wr_data;
    wb_en = 1'b0;
    wb_sel = cmm_pkg::data_reg(cmd.reg_b);
    if (fire) begin
      case (cmd.op)
        cmm_pkg::OP_USER_STACK_TRANSFER: begin
          // RULE1: stack pointer into address register
          wa_en = cmd.to_reg;
          wa_sel = cmm_pkg::addr_reg(cmd.reg_a);
          wa_data = usp_r;
        end
        cmm_pkg::OP_CONTROL_REGISTER_MOVE: begin
          // RULE2: control register into general register
          wa_en = cmd.to_reg;
          wa_sel = cmd.reg_a;
          wa_data = ctrl_rd;
        end
        cmm_pkg::OP_QUICK_IMMEDIATE_LOAD: begin
          // RULE5: sign extend immediate byte
          wa_en = 1'b1;
          wa_sel = dreg_a;
          wa_data = cmm_pkg::sext8(cmd.imm8);
        end
        cmm_pkg::OP_MULTIPLY: begin
          // RULE7: low into first register, high into second only in sixty-four bit mode
          wa_en = 1'b1;
          wa_sel = dreg_a;
          wa_data = prod_lo;
          wb_en = (cmd.mul_mode == cmm_pkg::MUL_L64);
        end
        default: ;
      endcase
    end else if (mem_load) begin
      case (cmd_r.op)
        cmm_pkg::OP_MULTI_REGISTER_TRANSFER: begin
          // RULE3: loaded words sign extended
          wa_en = 1'b1;
          wa_sel = cur_r;
          wa_data = (cmd_r.size == cmm_pkg::SZ_WORD) ? cmm_pkg::sext16(mem_rdata[15:0]) : mem_rdata;
        end
        cmm_pkg::OP_BYTE_LANE_MOVE: begin
          // RULE4: byte placed back into its lane
          wa_en = 1'b1;
          wa_sel = cmm_pkg::data_reg(cmd_r.reg_a);
          old = rf_r[wa_sel];
          sh = cmm_pkg::lane_shift(nlanes, cur_r[2:0]);
          wa_data = (old & ~(cmm_pkg::BYTE_MASK << sh)) | ((mem_rdata & cmm_pkg::BYTE_MASK) << sh);
        end
        cmm_pkg::OP_ALTERNATE_SPACE_MOVE: begin
          // address registers take the whole extended value
          wa_en = 1'b1;
          wa_sel = cmd_r.reg_a;
          old = rf_r[wa_sel];
          unique case (cmd_r.size)
            cmm_pkg::SZ_BYTE: wa_data = wa_sel[3] ? cmm_pkg::sext8(mem_rdata[7:0])
                                                  : {old[31:8], mem_rdata[7:0]};
            cmm_pkg::SZ_WORD: wa_data = wa_sel[3] ? cmm_pkg::sext16(mem_rdata[15:0])
                                                  : {old[31:16], mem_rdata[15:0]};
            default: wa_data = mem_rdata;
          endcase
        end
        default: ;
      endcase
    end
    if (!wa_en && rf_wr_en) begin
      wa_en = 1'b1;
      wa_sel = rf_wr_sel;
      wa_data = rf_wr_data;
    end
  end

  // register file storage; port b wins a same-register collision
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int i = 0; i < cmm_pkg::REG_COUNT; i++) begin
        rf_r[i] <= '0;
      end
    end else begin
      if (wa_en) begin
        rf_r[wa_sel] <= wa_data;
      end
      if (wb_en) begin
        rf_r[wb_sel] <= prod_hi;
      end
    end
  end

  // state word, stack pointer and control registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sw_r <= cmm_pkg::SW_RESET;
      usp_r <= '0;
      vbr_r <= '0;
      sfc_r <= '0;
      dfc_r <= '0;
    end else if (fire) begin
      case (cmd.op)
        // RULE10: flag write keeps the upper byte
        cmm_pkg::OP_FLAGS_TO: sw_r <= (sw_r & ~cmm_pkg::FLAGS_MASK) | (cmd.src_data[15:0] & cmm_pkg::FLAGS_MASK);
        cmm_pkg::OP_STATE_TO: sw_r <= cmd.src_data[15:0];
        cmm_pkg::OP_USER_STACK_TRANSFER: begin
          // RULE1: address register into stack pointer
          if (!cmd.to_reg) begin
            usp_r <= rf_r[cmm_pkg::addr_reg(cmd.reg_a)];
          end
        end
        cmm_pkg::OP_CONTROL_REGISTER_MOVE: begin
          // RULE2: general register into control register
          if (!cmd.to_reg) begin
            case (cmd.ctrl_code)
              cmm_pkg::CTRL_SRC_SPACE: sfc_r <= rf_r[cmd.reg_a][2:0];
              cmm_pkg::CTRL_DST_SPACE: dfc_r <= rf_r[cmd.reg_a][2:0];
              cmm_pkg::CTRL_USER_STACK: usp_r <= rf_r[cmd.reg_a];
              cmm_pkg::CTRL_VECTOR_BASE: vbr_r <= rf_r[cmd.reg_a];
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end
  end

  // compose the next memory beat from the held instruction
  always_comb begin
    beat_left = 1'b0;
    beat_cur = '0;
    beat_step = '0;
    beat.we = !cmd_r.to_reg;
    beat.addr = addr_r;
    beat.size = cmd_r.size;
    beat.fc = supervisor ? cmm_pkg::FC_SUPER_DATA : cmm_pkg::FC_USER_DATA;
    beat.wdata = '0;
    case (cmd_r.op)
      cmm_pkg::OP_MULTI_REGISTER_TRANSFER: begin
        // RULE3: consecutive words or longwords
        beat_left = (list_r != 16'h0000);
        beat_cur = cmm_pkg::lowest_set(list_r);
        beat_step = cmm_pkg::size_bytes(cmd_r.size);
        beat.wdata = (cmd_r.size == cmm_pkg::SZ_WORD) ? {16'h0000, rf_r[beat_cur][15:0]}
                                                      : rf_r[beat_cur];
      end
      cmm_pkg::OP_BYTE_LANE_MOVE: begin
        // RULE4: most significant lane first
        beat_left = (lane_r != nlanes);
        beat_cur = {1'b0, lane_r};
        beat_step = cmm_pkg::LANE_STEP;
        beat.size = cmm_pkg::SZ_BYTE;
        beat.wdata = (rf_r[cmm_pkg::data_reg(cmd_r.reg_a)] >> cmm_pkg::lane_shift(nlanes, lane_r))
                     & cmm_pkg::BYTE_MASK;
      end
      cmm_pkg::OP_ALTERNATE_SPACE_MOVE: begin
        // RULE6: qualifier from the space code registers
        beat_left = (lane_r == 3'h0);
        beat_cur = cmd_r.reg_a;
        beat.fc = cmd_r.to_reg ? sfc_r : dfc_r;
        beat.wdata = rf_r[cmd_r.reg_a];
      end
      default: ;
    endcase
  end

  // beat sequencer; one idle setup cycle between beats keeps outputs registered
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r <= cmm_pkg::ST_IDLE;
      cmd_r <= '0;
      list_r <= '0;
      addr_r <= '0;
      lane_r <= '0;
      cur_r <= '0;
      mem_r <= '0;
    end else begin
      unique case (state_r)
        cmm_pkg::ST_IDLE: begin
          if (fire && is_mem) begin
            cmd_r <= cmd;
            list_r <= cmd.reg_list;
            lane_r <= '0;
            // RULE4: base register plus displacement
            addr_r <= (cmd.op == cmm_pkg::OP_BYTE_LANE_MOVE)
                      ? rf_r[cmm_pkg::addr_reg(cmd.reg_b)] + cmm_pkg::sext16(cmd.disp16)
                      : cmd.ea_addr;
            state_r <= cmm_pkg::ST_SETUP;
          end
        end
        cmm_pkg::ST_SETUP: begin
          if (beat_left) begin
            mem_r <= beat;
            cur_r <= beat_cur;
            list_r <= list_r & ~(16'h0001 << beat_cur);
            lane_r <= lane_r + 3'h1;
            addr_r <= addr_r + beat_step;
            state_r <= cmm_pkg::ST_MEM;
          end else begin
            state_r <= cmm_pkg::ST_IDLE;
          end
        end
        cmm_pkg::ST_MEM: begin
          if (mem_ack) begin
            state_r <= cmm_pkg::ST_SETUP;
          end
        end
      endcase
    end
  end

  // completion, fault and effective-address result
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      done_r <= 1'b0;
      fault_r <= 1'b0;
      res_valid_r <= 1'b0;
      res_r <= '0;
    end else begin
      done_r <= (fire && !is_mem) || (state_r == cmm_pkg::ST_SETUP && !beat_left);
      // RULE9: one-cycle privilege violation pulse
      fault_r <= fault_now;
      res_valid_r <= 1'b0;
      if (fire) begin
        case (cmd.op)
          cmm_pkg::OP_DECIMAL_NEGATE: begin
            // RULE8: decimal result back to the operand
            res_valid_r <= 1'b1;
            res_r <= {24'h00_0000, bcd_out};
          end
          cmm_pkg::OP_FLAGS_FROM, cmm_pkg::OP_STATE_FROM: begin
            // RULE10: sixteen-bit state word alternate_space_move
            res_valid_r <= 1'b1;
            res_r <= {16'h0000, sw_r};
          end
          default: ;
        endcase
      end
    end
  end
endmodule

/* cmm_core_assertions.sv */
/* port checker for cmm_core, bound from the bench top file.
   assumes one clock domain with a synchronous active-low reset. */
`timescale 1ns/1ps
module cmm_core_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // instruction port
  input wire logic cmd_valid,
  input wire cmm_pkg::cmm_cmd_s cmd,
  input wire logic cmd_ready,
  input wire logic done,
  input wire logic priv_fault,
  input wire logic res_valid,
  input wire logic [31:0] res_data,
  // memory port and state
  input wire logic mem_req,
  input wire cmm_pkg::cmm_mem_s mem,
  input wire logic mem_ack,
  input wire logic [15:0] processor_state_word,
  input wire logic [31:0] user_stack_pointer
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // an accepted instruction, the privilege bit and the guarded ops
  wire tk = cmd_valid && cmd_ready;
  wire sup = processor_state_word[cmm_pkg::SW_SUPER_BIT];
  wire prv = cmd.op inside {cmm_pkg::OP_USER_STACK_TRANSFER, cmm_pkg::OP_CONTROL_REGISTER_MOVE,
    cmm_pkg::OP_ALTERNATE_SPACE_MOVE, cmm_pkg::OP_STATE_TO, cmm_pkg::OP_STATE_FROM};

  chk_quick_done: assert property (tk && cmd.op == cmm_pkg::OP_QUICK_IMMEDIATE_LOAD
    |=> done && !priv_fault) else $error("quick load late");
  chk_priv_block: assert property (tk && prv && !sup
    |=> priv_fault && !done && $stable(user_stack_pointer)) else $error("privileged op ran");
  chk_flags_low: assert property (tk && cmd.op == cmm_pkg::OP_FLAGS_TO
    |=> done && processor_state_word == {$past(processor_state_word[15:8]),
    $past(cmd.src_data[7:0])}) else $error("flag write wide");
  chk_state_read: assert property (tk && cmd.op == cmm_pkg::OP_STATE_FROM && sup
    |=> res_valid && res_data == {16'h0, $past(processor_state_word)})
    else $error("state read bad");
  chk_negate_res: assert property (tk && cmd.op == cmm_pkg::OP_DECIMAL_NEGATE
    |=> res_valid && done && res_data[31:8] == 24'h0) else $error("negate lost");
  chk_ready_busy: assert property (mem_req |-> !cmd_ready)
    else $error("ready while busy");
  chk_beat_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem))
    else $error("beat moved");
  chk_beat_gap: assert property (mem_req && mem_ack |=> !mem_req ##1 (mem_req ^ done))
    else $error("beat spacing wrong");
  chk_usp_quiet: assert property (!tk |=> $stable(user_stack_pointer))
    else $error("stack pointer moved");

  // main scenarios reached
  cov_mul: cover property (tk && cmd.op == cmm_pkg::OP_MULTIPLY);
  cov_store: cover property (mem_req && mem_ack && mem.we);
  cov_fault: cover property (priv_fault);
endmodule

/* cpu_move_multiply_ops_tb_top.sv */
/* bench for cmm_core: drives instructions, answers beats, judges results.
   assumes cmm_pkg compiled first. */
`timescale 1ns/1ps
module cpu_move_multiply_ops_tb_top;
  // clock, reset and tallies
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  int bad_count = 0;
  int compares = 0;
  // stimulus side
  logic cmd_valid = 1'b0;
  cmm_pkg::cmm_cmd_s cmd = '0;
  logic mem_ack = 1'b0;
  logic [31:0] mem_rdata = '0;
  logic rf_wr_en = 1'b0;
  logic [3:0] rf_wr_sel = '0;
  logic [31:0] rf_wr_data = '0;
  logic [3:0] rf_rd_sel = '0;
  // observed side
  logic cmd_ready, done, priv_fault, res_valid, mem_req;
  logic [31:0] res_data, rf_rd_data, user_stack_pointer;
  logic [15:0] processor_state_word;
  cmm_pkg::cmm_mem_s mem;
  cmm_pkg::cmm_cmd_s c;

  always #10 ref_clk = ~ref_clk;

  cmm_core u_dut (.ref_clk, .rstn, .cmd_valid, .cmd, .cmd_ready, .done, .priv_fault,
    .res_valid, .res_data, .mem_req, .mem, .mem_ack, .mem_rdata, .rf_wr_en, .rf_wr_sel,
    .rf_wr_data, .rf_rd_sel, .rf_rd_data, .processor_state_word, .user_stack_pointer);

  task automatic print_verdict();
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmpb(input logic g, input logic e);
    cmp32({31'h0, g}, {31'h0, e});
  endtask

  // blank instruction, longword size
  function automatic cmm_pkg::cmm_cmd_s nc(input cmm_pkg::cmm_op_e o);
    nc = '0;
    nc.op = o;
    nc.size = cmm_pkg::SZ_LONG;
  endfunction

  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    @(posedge ref_clk);
    rf_wr_en <= 1'b1;
    rf_wr_sel <= s;
    rf_wr_data <= d;
    @(posedge ref_clk);
    rf_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] s, input logic [31:0] e);
    @(posedge ref_clk);
    rf_rd_sel <= s;
    @(negedge ref_clk);
    cmp32(rf_rd_data, e);
  endtask

  // offer one instruction; k asks for the done pulse
  task automatic op(input cmm_pkg::cmm_cmd_s x, input logic k);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= x;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    @(negedge ref_clk);
    cmpb(done, k);
  endtask

  task automatic fin();
    int n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    cmpb(done, 1'b1);
  endtask

  // serve one beat; writes judged on sized lanes
  task automatic beat(input logic [31:0] a, input logic [31:0] d, input logic w,
    input logic [2:0] f);
    int n = 0;
    logic [31:0] m;
    while (mem_req !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    m = (mem.size == cmm_pkg::SZ_BYTE) ? 32'h0000_00ff :
      (mem.size == cmm_pkg::SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
    cmp32(mem.addr, a);
    cmpb(mem.we, w);
    cmp32({29'h0, mem.fc}, {29'h0, f});
    if (w) cmp32(mem.wdata & m, d);
    @(posedge ref_clk);
    mem_ack <= 1'b1;
    mem_rdata <= d;
    @(posedge ref_clk);
    mem_ack <= 1'b0;
    // a released bus must not keep showing the old data
    mem_rdata <= ~d;
    @(negedge ref_clk);
  endtask

  task automatic mu(input logic sg, input cmm_pkg::cmm_mul_e md, input logic [31:0] d,
    input logic [31:0] s, input logic [31:0] lo);
    wr(4'h2, d);
    c = nc(cmm_pkg::OP_MULTIPLY);
    c.mul_signed = sg;
    c.mul_mode = md;
    c.reg_a = 4'h2;
    c.reg_b = 4'h7;
    c.src_data = s;
    op(c, 1'b1);
    rd(4'h2, lo);
  endtask

  task automatic t_move();
    c = nc(cmm_pkg::OP_QUICK_IMMEDIATE_LOAD);
    c.reg_a = 4'h3;
    c.imm8 = 8'h80;
    op(c, 1'b1);
    rd(4'h3, 32'hffff_ff80);
    mu(1'b1, cmm_pkg::MUL_W16, 32'h0000_0003, 32'h0000_fffe, 32'hffff_fffa);
    mu(1'b1, cmm_pkg::MUL_L32, 32'h0000_0007, 32'hffff_fffd, 32'hffff_ffeb);
    mu(1'b0, cmm_pkg::MUL_L64, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_0001);
    rd(4'h7, 32'hffff_fffe);
    mu(1'b1, cmm_pkg::MUL_L64, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_0001);
    rd(4'h7, 32'h0);
    wr(4'ha, 32'h1234_5678);
    c = nc(cmm_pkg::OP_USER_STACK_TRANSFER);
    c.reg_a = 4'h2;
    op(c, 1'b1);
    cmp32(user_stack_pointer, 32'h1234_5678);
    c.to_reg = 1'b1;
    c.reg_a = 4'h5;
    op(c, 1'b1);
    rd(4'hd, 32'h1234_5678);
    wr(4'h0, 32'h0000_0002);
    c = nc(cmm_pkg::OP_CONTROL_REGISTER_MOVE);
    c.ctrl_code = cmm_pkg::CTRL_SRC_SPACE;
    op(c, 1'b1);
    wr(4'h0, 32'h0001_0006);
    c.ctrl_code = cmm_pkg::CTRL_DST_SPACE;
    op(c, 1'b1);
    c.to_reg = 1'b1;
    c.reg_a = 4'h4;
    c.ctrl_code = cmm_pkg::CTRL_USER_STACK;
    op(c, 1'b1);
    rd(4'h4, 32'h1234_5678);
  endtask

  task automatic t_mem();
    c = nc(cmm_pkg::OP_ALTERNATE_SPACE_MOVE);
    c.to_reg = 1'b1;
    c.reg_a = 4'h4;
    c.ea_addr = 32'h0000_0400;
    op(c, 1'b0);
    beat(32'h0000_0400, 32'h5566_7788, 1'b0, 3'h2);
    fin();
    rd(4'h4, 32'h5566_7788);
    c.to_reg = 1'b0;
    op(c, 1'b0);
    beat(32'h0000_0400, 32'h5566_7788, 1'b1, 3'h6);
    fin();
    wr(4'h5, 32'ha1b2_c3d4);
    wr(4'h9, 32'h0000_1000);
    wr(4'h6, 32'hffff_0000);
    c = nc(cmm_pkg::OP_BYTE_LANE_MOVE);
    c.reg_a = 4'h5;
    c.reg_b = 4'h1;
    c.disp16 = 16'hfff0;
    op(c, 1'b0);
    for (int i = 0; i < 4; i++) begin
      beat(32'h0000_0ff0 + 2 * i, {24'h0, 8'(32'ha1b2_c3d4 >> (24 - 8 * i))}, 1'b1, 3'h5);
    end
    fin();
    c.to_reg = 1'b1;
    c.size = cmm_pkg::SZ_WORD;
    c.reg_a = 4'h6;
    op(c, 1'b0);
    beat(32'h0000_0ff0, 32'h0000_0011, 1'b0, 3'h5);
    beat(32'h0000_0ff2, 32'h0000_0022, 1'b0, 3'h5);
    fin();
    rd(4'h6, 32'hffff_1122);
    c = nc(cmm_pkg::OP_MULTI_REGISTER_TRANSFER);
    c.reg_list = 16'h0011;
    c.ea_addr = 32'h0000_4000;
    op(c, 1'b0);
    beat(32'h0000_4000, 32'h0001_0006, 1'b1, 3'h5);
    beat(32'h0000_4004, 32'h5566_7788, 1'b1, 3'h5);
    fin();
    c.to_reg = 1'b1;
    c.size = cmm_pkg::SZ_WORD;
    c.reg_list = 16'h0102;
    op(c, 1'b0);
    beat(32'h0000_4000, 32'h0000_8001, 1'b0, 3'h5);
    beat(32'h0000_4002, 32'h0000_7fff, 1'b0, 3'h5);
    fin();
    rd(4'h1, 32'hffff_8001);
    rd(4'h8, 32'h0000_7fff);
  endtask

  task automatic t_state();
    cmm_pkg::cmm_op_e pl[5];
    pl = '{cmm_pkg::OP_USER_STACK_TRANSFER, cmm_pkg::OP_CONTROL_REGISTER_MOVE,
      cmm_pkg::OP_ALTERNATE_SPACE_MOVE, cmm_pkg::OP_STATE_TO, cmm_pkg::OP_STATE_FROM};
    c = nc(cmm_pkg::OP_DECIMAL_NEGATE);
    c.src_data = 32'h0000_0025;
    op(c, 1'b1);
    cmp32(res_data, 32'h0000_0075);
    c = nc(cmm_pkg::OP_STATE_TO);
    c.src_data = 32'h0000_2010;
    op(c, 1'b1);
    c = nc(cmm_pkg::OP_DECIMAL_NEGATE);
    c.src_data = 32'h0000_0025;
    op(c, 1'b1);
    cmp32(res_data, 32'h0000_0074);
    c = nc(cmm_pkg::OP_FLAGS_TO);
    c.src_data = 32'h0000_ffab;
    op(c, 1'b1);
    cmp32({16'h0, processor_state_word}, 32'h0000_20ab);
    op(nc(cmm_pkg::OP_STATE_FROM), 1'b1);
    cmp32(res_data, 32'h0000_20ab);
    op(nc(cmm_pkg::OP_STATE_TO), 1'b1);
    // in user state each guarded op faults and does nothing
    foreach (pl[i]) begin
      op(nc(pl[i]), 1'b0);
      cmpb(priv_fault, 1'b1);
    end
    cmp32(user_stack_pointer, 32'h1234_5678);
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    cmp32({16'h0, processor_state_word}, 32'h0000_2000);
    t_move();
    t_mem();
    t_state();
    print_verdict();
  end

  // watchdog, far past the run's length
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule

bind cmm_core cmm_core_assertions u_chk (.ref_clk, .rstn, .cmd_valid, .cmd, .cmd_ready, .done,
  .priv_fault, .res_valid, .res_data, .mem_req, .mem, .mem_ack, .processor_state_word,
  .user_stack_pointer);
